// ### vfd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module vfd_host_model (
    output logic o_sck,
    output logic o_select_n,
    output logic o_sdata
);
    initial begin
        o_sck = 1'b0;
        o_select_n = 1'b1;
        o_sdata = 1'b0;
    end
    // The serial clock stands low between frames; words go out top bit first.
    task automatic send(input logic [7:0] w[$], input int nbits);
        int i;
        #3.7;
        o_select_n = 1'b0;
        for (i = 0; i < nbits; i++) begin
            o_sdata = w[i / 8][7 - i % 8];
            #6 o_sck = 1'b1;
            #6 o_sck = 1'b0;
        end
        #12 o_select_n = 1'b1;
        // A released line must not keep looking like the last bit.
        o_sdata = ~o_sdata;
        #150;
    endtask
endmodule
`default_nettype wire

// ### vfd_pkg.sv
package vfd_pkg;

    // Display geometry.
    localparam int NUM_GRIDS = 14;
    localparam int NUM_SEGS = 16;
    localparam int RAM_DEPTH = 32;
    localparam int WORD_BITS = 8;

    // Scan timing: a blank interval in oscillator periods (the system clock is the oscillator), then blanks per slot and slots per refresh.
    localparam int BLANK_OSC_FACTOR_A = 16;
    localparam int BLANK_OSC_FACTOR_B = 2;
    localparam int BLANK_CYCLES = BLANK_OSC_FACTOR_A * BLANK_OSC_FACTOR_B;
    localparam int SLOT_BLANKS = 16;
    localparam int REFRESH_SLOTS = 14;

    // First-word decode.
    localparam int CMD1_FLAG_BIT = 7;
    localparam logic [1:0] TOP_ADDR = 2'h0;
    localparam logic [1:0] TOP_CMD2 = 2'h1;
    localparam int ADDR_MSB = 4;
    localparam int START_MSB = 3;
    localparam int CMD1_MSB = 6;

    // Scan control word fields.
    localparam int DUTY_MSB = 6;
    localparam int DUTY_LSB = 4;
    localparam int DISPLAY_ON_BIT = 3;
    localparam int LOOP_MSB = 2;
    localparam int LOOP_LSB = 0;

    // Reset values, the forbidden start character and the loop length base.
    localparam logic [6:0] SCAN_CTRL_RESET = 7'h00;
    localparam logic [3:0] START_CHAR_RESET = 4'h1;
    localparam logic [3:0] START_CHAR_FORBIDDEN = 4'hf;
    localparam logic [4:0] RAM_PTR_RESET = 5'h00;
    localparam logic [3:0] LOOP_LEN_BASE = 4'h7;

    typedef struct packed {
        logic first;
        logic [WORD_BITS-1:0] data;
    } vfd_word_t;

    typedef enum logic [1:0] {
        VFD_MODE_IDLE = 2'b00,
        VFD_MODE_DATA = 2'b01,
        VFD_MODE_DISCARD = 2'b10
    } vfd_mode_t;

    // Number of lit sixteenths for each duty code.
    function automatic logic [4:0] duty_sixteenths(input logic [2:0] code);
        duty_sixteenths = (code == 3'h7) ? 5'h0f : {1'b0, code, 1'b0} + 5'h02;
    endfunction

    function automatic logic [3:0] loop_len(input logic [2:0] code);
        loop_len = LOOP_LEN_BASE + {1'b0, code};
    endfunction

    // Character shown on a grid: inside the loop the characters 0..N rotate
    // from the start character, outside it grid g keeps character g+1.
    function automatic logic [3:0] char_for_grid(input logic [3:0] grid,
                                                 input logic [3:0] start,
                                                 input logic [3:0] n);
        logic [4:0] sum;
        sum = {1'b0, start} + {1'b0, grid};
        if (grid >= n) begin
            char_for_grid = grid + 4'h1;
        end else if (sum > {1'b0, n}) begin
            char_for_grid = 4'(sum - {1'b0, n} - 5'h01);
        end else begin
            char_for_grid = sum[3:0];
        end
    endfunction

endpackage

// ### vfd_scan_timer.sv
`timescale 1ns/1ps
`default_nettype none
module vfd_scan_timer (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [2:0] i_duty_code,
    output logic [3:0] o_grid,
    output logic o_lit,
    output logic o_slot_start
);
    import vfd_pkg::*;

    logic [4:0] tick_q, tick_d;
    logic [3:0] blank_q, blank_d;
    logic [3:0] grid_q, grid_d;

    always_comb begin
        tick_d = tick_q + 5'h01;
        blank_d = blank_q;
        grid_d = grid_q;
        if (tick_q == 5'(BLANK_CYCLES - 1)) begin
            tick_d = 5'h00;
            blank_d = blank_q + 4'h1;
            if (blank_q == 4'(SLOT_BLANKS - 1)) begin
                blank_d = 4'h0;
                grid_d = (grid_q == 4'(REFRESH_SLOTS - 1)) ? 4'h0 : grid_q + 4'h1;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            tick_q <= 5'h00;
            blank_q <= 4'h0;
            grid_q <= 4'h0;
        end else begin
            tick_q <= tick_d;
            blank_q <= blank_d;
            grid_q <= grid_d;
        end
    end

    // The lit part of a slot comes first; at most 15 of 16 intervals are lit,
    // so at least one blank interval always separates two grids.
    assign o_grid = grid_q;
    assign o_lit = ({1'b0, blank_q} < duty_sixteenths(i_duty_code));
    assign o_slot_start = (tick_q == 5'h00) && (blank_q == 4'h0);
endmodule
`default_nettype wire

// ### vfd_serial_rx.sv
`timescale 1ns/1ps
`default_nettype none
module vfd_serial_rx (
    input wire logic i_sck,
    input wire logic i_reset_n,
    input wire logic i_select_n,
    input wire logic i_sdata,
    output vfd_pkg::vfd_word_t o_word,
    output logic o_word_toggle
);
    import vfd_pkg::*;

    logic [2:0] bit_cnt_q, bit_cnt_d;
    logic [WORD_BITS-1:0] shift_q, shift_d;
    logic first_q, first_d;
    vfd_word_t word_q, word_d;
    logic toggle_q, toggle_d;

    // Select high holds the frame logic cleared, so clock edges outside a
    // frame are never counted.
    always_comb begin
        shift_d = {shift_q[WORD_BITS-2:0], i_sdata};
        bit_cnt_d = bit_cnt_q + 3'h1;
        first_d = first_q;
        word_d = word_q;
        toggle_d = toggle_q;
        if (bit_cnt_q == 3'h7) begin
            word_d.data = shift_d;
            word_d.first = first_q;
            first_d = 1'b0;
            toggle_d = ~toggle_q;
        end
    end

    always_ff @(posedge i_sck or posedge i_select_n) begin
        if (i_select_n) begin
            bit_cnt_q <= 3'h0;
            first_q <= 1'b1;
            shift_q <= 8'h00;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            first_q <= first_d;
            shift_q <= shift_d;
        end
    end

    // The finished word and its toggle survive the frame end; they are only
    // cleared by the device reset.
    always_ff @(posedge i_sck or negedge i_reset_n) begin
        if (!i_reset_n) begin
            word_q <= '0;
            toggle_q <= 1'b0;
        end else if (!i_select_n) begin
            word_q <= word_d;
            toggle_q <= toggle_d;
        end
    end

    assign o_word = word_q;
    assign o_word_toggle = toggle_q;
endmodule
`default_nettype wire

// ### vfd_shift_scan_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module vfd_shift_scan_ctrl (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_hard_reset_n,
    input wire logic i_sck,
    input wire logic i_select_n,
    input wire logic i_sdata,
    output logic [vfd_pkg::NUM_GRIDS-1:0] o_grid,
    output logic [vfd_pkg::NUM_SEGS-1:0] o_seg
);
    import vfd_pkg::*;

    vfd_word_t rx_word;
    logic rx_toggle;

    logic hr_meta_q, hr_sync_q;
    logic sel_meta_q, sel_sync_q, sel_prev_q;
    logic tog_meta_q, tog_sync_q, tog_prev_q;
    logic rst;

    vfd_word_t pend_q, pend_d;
    logic pend_valid_q, pend_valid_d;
    logic end_pend_q, end_pend_d;
    vfd_mode_t mode_q, mode_d;
    logic [6:0] scan_control_word_q, scan_control_word_d;
    logic [3:0] start_character_select_q, start_character_select_d;
    logic [4:0] display_ram_pointer_q, display_ram_pointer_d;
    logic [WORD_BITS-1:0] ram_q [RAM_DEPTH];
    logic ram_we;
    logic [4:0] ram_waddr;
    logic [WORD_BITS-1:0] ram_wdata;
    logic [NUM_GRIDS-1:0] grid_q, grid_d;
    logic [NUM_SEGS-1:0] seg_q, seg_d;
    logic [NUM_SEGS-1:0] char_seg_q, char_seg_d;

    logic [3:0] scan_grid;
    logic scan_lit;
    logic slot_start;
    logic commit_en;
    vfd_word_t commit_w;
    logic new_word;
    logic frame_end;
    logic [3:0] char_idx;

    vfd_serial_rx u_rx (
        .i_sck(i_sck),
        .i_reset_n(i_reset_n),
        .i_select_n(i_select_n),
        .i_sdata(i_sdata),
        .o_word(rx_word),
        .o_word_toggle(rx_toggle)
    );

    vfd_scan_timer u_scan (
        .i_clk_sys(i_clk_sys),
        .i_rst(rst),
        .i_duty_code(scan_control_word_q[DUTY_MSB:DUTY_LSB]),
        .o_grid(scan_grid),
        .o_lit(scan_lit),
        .o_slot_start(slot_start)
    );

    // Pins from outside the clock domain pass two flops before use.
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            hr_meta_q <= 1'b1;
            hr_sync_q <= 1'b1;
            sel_meta_q <= 1'b1;
            sel_sync_q <= 1'b1;
            sel_prev_q <= 1'b1;
            tog_meta_q <= 1'b0;
            tog_sync_q <= 1'b0;
            tog_prev_q <= 1'b0;
        end else begin
            hr_meta_q <= i_hard_reset_n;
            hr_sync_q <= hr_meta_q;
            sel_meta_q <= i_select_n;
            sel_sync_q <= sel_meta_q;
            sel_prev_q <= sel_sync_q;
            tog_meta_q <= rx_toggle;
            tog_sync_q <= tog_meta_q;
            tog_prev_q <= tog_sync_q;
        end
    end

    assign rst = !i_reset_n || !hr_sync_q;

    // The received word is held for at least seven serial clocks after its
    // toggle, which outlasts the synchroniser, so it is read without flops.
    assign new_word = (tog_sync_q != tog_prev_q);
    assign frame_end = (sel_sync_q && !sel_prev_q) || end_pend_q;

    // A word becomes effective when select rises or, inside a multi-word
    // frame, when the next word completes behind it.
    always_comb begin
        pend_d = pend_q;
        pend_valid_d = pend_valid_q;
        end_pend_d = 1'b0;
        commit_en = 1'b0;
        commit_w = pend_q;
        if (new_word) begin
            commit_en = pend_valid_q;
            pend_d = rx_word;
            pend_valid_d = 1'b1;
            end_pend_d = sel_sync_q && !sel_prev_q;
        end else if (frame_end) begin
            commit_en = pend_valid_q;
            pend_valid_d = 1'b0;
        end
    end

    always_comb begin
        mode_d = mode_q;
        scan_control_word_d = scan_control_word_q;
        start_character_select_d = start_character_select_q;
        display_ram_pointer_d = display_ram_pointer_q;
        ram_we = 1'b0;
        ram_waddr = display_ram_pointer_q;
        ram_wdata = commit_w.data;
        if (commit_en) begin
            if (commit_w.first) begin
                if (commit_w.data[CMD1_FLAG_BIT]) begin
                    scan_control_word_d = commit_w.data[CMD1_MSB:0];
                    mode_d = VFD_MODE_DISCARD;
                end else if (commit_w.data[7:6] == TOP_CMD2) begin
                    if (commit_w.data[START_MSB:0] != START_CHAR_FORBIDDEN) begin
                        start_character_select_d = commit_w.data[START_MSB:0];
                    end
                    mode_d = VFD_MODE_DISCARD;
                end else begin
                    display_ram_pointer_d = commit_w.data[ADDR_MSB:0];
                    mode_d = VFD_MODE_DATA;
                end
            end else if (mode_q == VFD_MODE_DATA) begin
                ram_we = 1'b1;
                display_ram_pointer_d = display_ram_pointer_q + 5'h01;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (rst) begin
            pend_q <= '0;
            pend_valid_q <= 1'b0;
            end_pend_q <= 1'b0;
            mode_q <= VFD_MODE_IDLE;
            scan_control_word_q <= SCAN_CTRL_RESET;
            start_character_select_q <= START_CHAR_RESET;
            display_ram_pointer_q <= RAM_PTR_RESET;
        end else begin
            pend_q <= pend_d;
            pend_valid_q <= pend_valid_d;
            end_pend_q <= end_pend_d;
            mode_q <= mode_d;
            scan_control_word_q <= scan_control_word_d;
            start_character_select_q <= start_character_select_d;
            display_ram_pointer_q <= display_ram_pointer_d;
        end
    end

    // Pointer values 30 and 31 land in bytes that no grid ever shows.
    always_ff @(posedge i_clk_sys) begin
        if (rst) begin
            for (int i = 0; i < RAM_DEPTH; i++) begin
                ram_q[i] <= 8'h00;
            end
        end else if (ram_we) begin
            ram_q[ram_waddr] <= ram_wdata;
        end
    end

    // Character k keeps segments 7..0 at address 2k and 15..8 at 2k+1.
    assign char_idx = char_for_grid(scan_grid, start_character_select_q,
                                    loop_len(scan_control_word_q[LOOP_MSB:LOOP_LSB]));

    always_comb begin
        char_seg_d = char_seg_q;
        if (slot_start) begin
            char_seg_d = {ram_q[{char_idx, 1'b1}], ram_q[{char_idx, 1'b0}]};
        end
        grid_d = '0;
        seg_d = '0;
        if (scan_control_word_q[DISPLAY_ON_BIT] && scan_lit) begin
            grid_d[scan_grid] = 1'b1;
            seg_d = slot_start ? char_seg_d : char_seg_q;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (rst) begin
            char_seg_q <= '0;
            grid_q <= '0;
            seg_q <= '0;
        end else begin
            char_seg_q <= char_seg_d;
            grid_q <= grid_d;
            seg_q <= seg_d;
        end
    end

    assign o_grid = grid_q;
    assign o_seg = seg_q;
endmodule
`default_nettype wire

// ### vfd_shift_scan_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module vfd_shift_scan_ctrl_asserts (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_hard_reset_n,
    input wire logic i_select_n,
    input wire logic [vfd_pkg::NUM_GRIDS-1:0] o_grid,
    input wire logic [vfd_pkg::NUM_SEGS-1:0] o_seg
);
    import vfd_pkg::*;
    logic [NUM_GRIDS-1:0] pg_q;
    logic [NUM_GRIDS-1:0] lg_q;
    logic [9:0] lc_q;
    logic [11:0] gap_q;
    logic [4:0] hr_q;
    logic [10:0] quiet_q;
    logic lv_q;
    logic rst;
    logic rise;
    logic fall;
    // The pin reset reaches the core late, so its tail is masked as well.
    // A frame may switch the display or its duty in mid-slot, which cuts a
    // lit run legally, so timing checks rest until two slots after a frame.
    assign rst = !i_reset_n || !i_hard_reset_n || (|hr_q) || (quiet_q < 11'd1100);
    assign rise = (o_grid != '0) && (pg_q == '0);
    assign fall = (o_grid == '0) && (pg_q != '0);
    always_ff @(posedge i_clk_sys) begin
        hr_q <= {hr_q[3:0], !i_hard_reset_n};
        if (!i_select_n) begin
            quiet_q <= 11'h000;
        end else if (quiet_q != 11'h7ff) begin
            quiet_q <= quiet_q + 11'h001;
        end
        if (rst) begin
            pg_q <= o_grid;
            lg_q <= '0;
            lc_q <= '0;
            gap_q <= 12'hfff;
            lv_q <= 1'b0;
        end else begin
            pg_q <= o_grid;
            lv_q <= lv_q | rise;
            lg_q <= rise ? o_grid : lg_q;
            lc_q <= (o_grid != '0) ? lc_q + 10'h001 : 10'h000;
            gap_q <= rise ? 12'h001 : gap_q + {11'h000, gap_q != 12'hfff};
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    property p_reset_blank;
        !i_reset_n |=> (o_grid == '0) && (o_seg == '0);
    endproperty
    a_reset_blank: assert property (p_reset_blank) else $error("outputs lit in reset");
    property p_hard_blank;
        (!i_hard_reset_n) [*4] |=> o_grid == '0;
    endproperty
    a_hard_blank: assert property (p_hard_blank) else $error("grid lit in pin reset");
    property p_onehot;
        disable iff (rst) $onehot0(o_grid);
    endproperty
    a_onehot: assert property (p_onehot) else $error("several grids lit");
    property p_seg_dark;
        disable iff (rst) (o_grid == '0) |-> (o_seg == '0);
    endproperty
    a_seg_dark: assert property (p_seg_dark) else $error("segment lit without grid");
    property p_lit_min;
        disable iff (rst) (fall && lv_q) |-> (lc_q >= 10'd32) && (lc_q % 10'd32 == 10'd0);
    endproperty
    a_lit_min: assert property (p_lit_min) else $error("lit time not whole intervals");
    property p_lit_max;
        disable iff (rst) (fall && lv_q) |-> lc_q <= 10'd480;
    endproperty
    a_lit_max: assert property (p_lit_max) else $error("lit time above fifteen intervals");
    property p_slot;
        disable iff (rst) (rise && gap_q <= 12'd512) |-> gap_q == 12'd512;
    endproperty
    a_slot: assert property (p_slot) else $error("grid slot shorter than 512 clocks");
    property p_order;
        disable iff (rst) (rise && gap_q == 12'd512) |->
            o_grid == {lg_q[NUM_GRIDS-2:0], lg_q[NUM_GRIDS-1]};
    endproperty
    a_order: assert property (p_order) else $error("grid scan out of order");
    property p_steady;
        disable iff (rst) (o_grid != '0 && pg_q != '0) |-> o_grid == pg_q;
    endproperty
    a_steady: assert property (p_steady) else $error("grid changed without gap");
endmodule
bind vfd_shift_scan_ctrl vfd_shift_scan_ctrl_asserts vfd_shift_scan_ctrl_asserts_i (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_hard_reset_n(i_hard_reset_n),
    .i_select_n(i_select_n),
    .o_grid(o_grid),
    .o_seg(o_seg)
);
`default_nettype wire

// ### vfd_shift_scan_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vfd_shift_scan_ctrl_tb;
    import vfd_pkg::*;
    logic i_clk_sys, i_reset_n, i_hard_reset_n, sck, sel_n, sdata;
    logic [NUM_GRIDS-1:0] o_grid;
    logic [NUM_SEGS-1:0] o_seg;
    logic [7:0] ram [32];
    int fails = 0;
    int n_tests = 0;
    int d, n;
    vfd_shift_scan_ctrl vfd_shift_scan_ctrl_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_hard_reset_n(i_hard_reset_n), .i_sck(sck), .i_select_n(sel_n), .i_sdata(sdata),
        .o_grid(o_grid), .o_seg(o_seg));
    vfd_host_model vfd_host_model_i (.o_sck(sck), .o_select_n(sel_n), .o_sdata(sdata));
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tx(input logic [7:0] w[$], input int nbits);
        vfd_host_model_i.send(w, nbits);
    endtask
    task automatic load_ram();
        logic [7:0] w[$];
        int i;
        w.push_back(8'h20);
        for (i = 0; i < 30; i++) begin
            ram[i] = 8'(i * 37 + 5);
            w.push_back(ram[i]);
        end
        tx(w, 248);
    endtask
    task automatic wait_grid(input int g);
        int t;
        for (t = 0; t < 8000; t++) begin
            @(negedge i_clk_sys);
            if (o_grid === 14'(1 << g)) return;
        end
        fails++;
        final_report();
    endtask
    // Counts one lit run; entered mid-run it returns the tail only.
    task automatic lit_run(output int cnt);
        int t;
        cnt = 0;
        for (t = 0; t < 16000 && (cnt == 0 || o_grid !== '0); t++) begin
            @(negedge i_clk_sys);
            if (o_grid !== '0) cnt++;
        end
        if (t == 16000) begin
            fails++;
            final_report();
        end
    endtask
    task automatic check_grids(input int start, input int len);
        int g, c;
        repeat (520) @(negedge i_clk_sys);
        for (g = 0; g < NUM_GRIDS; g++) begin
            c = (g >= len) ? g + 1 : (start + g) % (len + 1);
            wait_grid(g);
            check("segments", o_seg, {ram[2 * c + 1], ram[2 * c]});
        end
    endtask
    initial begin
        i_reset_n = 1'b0;
        i_hard_reset_n = 1'b1;
        repeat (8) @(posedge i_clk_sys);
        #2 i_reset_n = 1'b1;
        load_ram();
        repeat (600) @(negedge i_clk_sys);
        check("grid_off", o_grid, 16'h0000);
        tx('{8'h8d}, 8);
        check_grids(1, 12);
        // The second word of a command frame must not reach the start field.
        tx('{8'h42, 8'h43}, 16);
        check_grids(2, 12);
        tx('{8'h4f}, 8);
        tx('{8'h1e, 8'haa, 8'hbb, 8'h5a}, 32);
        ram[0] = 8'h5a;
        check_grids(2, 12);
        tx('{8'h8f}, 8);
        check_grids(2, 14);
        for (d = 0; d < 8; d++) begin
            lit_run(n);
            tx('{8'h85}, 8);
            repeat (40) @(negedge i_clk_sys);
            check("grid_off", o_grid, 16'h0000);
            tx('{{1'b1, 3'(d), 1'b1, 3'h5}}, 8);
            lit_run(n);
            lit_run(n);
            check("lit_len", 16'(n), 16'((d == 7 ? 15 : 2 * d + 2) * 32));
        end
        @(posedge i_clk_sys);
        #2 i_hard_reset_n = 1'b0;
        repeat (6) @(posedge i_clk_sys);
        #2 i_hard_reset_n = 1'b1;
        repeat (40) @(negedge i_clk_sys);
        check("grid_off", o_grid, 16'h0000);
        load_ram();
        tx('{8'h8d}, 8);
        check_grids(1, 12);
        final_report();
    end
endmodule
`default_nettype wire
